// ### core/ccd_regs.vh
// Register indices, field positions and reset values of the channel dividers
`ifndef CCD_REGS_VH
`define CCD_REGS_VH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define CCD_IDX_DIV0_COUNTS 10'h190
`define CCD_IDX_DIV0_CONTROL 10'h191
`define CCD_IDX_CH0_POWER 10'h192
`define CCD_IDX_DIV1_COUNTS 10'h193
`define CCD_IDX_DIV1_CONTROL 10'h194
`define CCD_IDX_CH1_POWER 10'h195
`define CCD_IDX_DIV2_COUNTS 10'h196
`define CCD_IDX_DIV2_CONTROL 10'h197
`define CCD_IDX_STATUS 10'h1a0

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CCD_CNT_LOW_HI 7
`define CCD_CNT_LOW_LO 4
`define CCD_CNT_HIGH_HI 3
`define CCD_CNT_HIGH_LO 0
`define CCD_CTL_BYPASS 7
`define CCD_CTL_IGNORE_SYNC 6
`define CCD_CTL_FORCE_HIGH 5
`define CCD_CTL_START_HIGH 4
`define CCD_CTL_PHASE_HI 3
`define CCD_CTL_PHASE_LO 0
`define CCD_PWR_DOWN 2
`define CCD_PWR_DCC_OFF 0
`define CCD_PWR_MASK 8'h05

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CCD_RST_DIV0_COUNTS 8'h77
`define CCD_RST_DIV1_COUNTS 8'h33
`define CCD_RST_DIV2_COUNTS 8'h11
`define CCD_RST_CONTROL 8'h00
`define CCD_RST_POWER 8'h00

// ------------------------------------------------------------
// Bus constants
// ------------------------------------------------------------
`define CCD_HTRANS_NONSEQ 2'b10
`define CCD_HTRANS_SEQ 2'b11
`define CCD_HSIZE_WORD 3'b010

`endif

// ### core/ccd_divider.v
// One programmable output divider channel
`default_nettype none

module ccd_divider #(
  parameter CW = 4
) (
  input wire clk,
  input wire reset_n,
  input wire src_level,
  input wire src_rise,
  input wire [CW-1:0] low_cnt,
  input wire [CW-1:0] high_cnt,
  input wire bypass,
  input wire ignore_sync,
  input wire force_high,
  input wire start_high,
  input wire [CW-1:0] phase,
  input wire sync_act,
  output reg div_out_q,
  output reg running_q
);

  reg [CW-1:0] cnt_q;
  reg [CW-1:0] ph_q;
  wire held;
  wire forced;
  wire [CW-1:0] load_cnt;
  wire [CW-1:0] cur_cnt;
  wire [CW-1:0] cur_ph;
  wire cur_lvl;

  assign held = sync_act & ~ignore_sync;
  assign forced = sync_act & ignore_sync;
  assign load_cnt = start_high ? high_cnt : low_cnt;
  assign cur_cnt = running_q ? cnt_q : load_cnt;
  assign cur_ph = running_q ? ph_q : phase;
  assign cur_lvl = running_q ? div_out_q : start_high;

  // ------------------------------------------------------------
  // Counter and output level
  // ------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_out_q <= 1'b0;
      cnt_q <= {CW{1'b0}};
      ph_q <= {CW{1'b0}};
      running_q <= 1'b0;
    end else if (bypass) begin
      div_out_q <= src_level;
      running_q <= 1'b0;
      cnt_q <= start_high ? high_cnt : low_cnt;
      ph_q <= phase;
    end else if (forced) begin
      div_out_q <= force_high;
      running_q <= 1'b0;
      cnt_q <= start_high ? high_cnt : low_cnt;
      ph_q <= phase;
    end else if (held) begin
      div_out_q <= start_high;
      running_q <= 1'b0;
      cnt_q <= start_high ? high_cnt : low_cnt;
      ph_q <= phase;
    end else begin
      // First running cycle starts from the start level and fresh
      // counts, so the first phase after reset is full length too
      running_q <= 1'b1;
      div_out_q <= cur_lvl;
      cnt_q <= cur_cnt;
      ph_q <= cur_ph;
      if (src_rise) begin
        if (cur_ph != {CW{1'b0}}) begin
          ph_q <= cur_ph - 1'b1;
        end else if (cur_cnt == {CW{1'b0}}) begin
          div_out_q <= ~cur_lvl;
          // Low lasts low_cnt+1 edges, high lasts high_cnt+1
          cnt_q <= cur_lvl ? low_cnt : high_cnt;
        end else begin
          cnt_q <= cur_cnt - 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### core/ccd_top.v
// Channel clock dividers with AHB-Lite register access
// ------------------------------------------------------------
// ------------------------------------------------------------
`include "ccd_regs.vh"
`default_nettype none

module ccd_top #(
  parameter NDIV = 3,
  parameter CW = 4
) (
  input wire clk,
  input wire reset_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire src_clk_level,
  input wire sync_req,
  output wire [NDIV-1:0] div_out,
  output reg [3*NDIV-1:0] pair_out_q,
  output reg [3*NDIV-1:0] pair_oe_q,
  output reg [NDIV-1:0] duty_cycle_correction_q
);

  // ------------------------------------------------------------
  // Register map (index: contents)
  // ------------------------------------------------------------
  // 0x190 divider0_counts: [7:4] low count, [3:0] high count
  // 0x191 divider0_control: [7] bypass, [6] ignore sync,
  //   [5] force level, [4] start level, [3:0] phase offset
  // 0x192 channel0_power_correction: [2] power-down,
  //   [0] correction off; other bits read zero
  // 0x193 divider1_counts: as divider0_counts
  // 0x194 divider1_control: as divider0_control
  // 0x195 channel1_power_correction: as channel0
  // 0x196 divider2_counts: as divider0_counts
  // 0x197 divider2_control: as divider0_control
  // 0x1a0 status, read-only: [6] sync, [5:3] running,
  //   [2:0] divider levels
  // Byte address is four times the index; all else reads zero
  // Count changes take effect at the next toggle or sync

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  reg [7:0] regs_q [0:7];
  reg src_prev_q;
  reg sync_meta_q;
  reg sync_q;
  wire src_rise;
  wire [NDIV-1:0] running;

  // ------------------------------------------------------------
  // Bus state
  // ------------------------------------------------------------
  reg wr_pend_q;
  reg rd_pend_q;
  reg [9:0] idx_q;
  wire trans_ok;
  wire [9:0] a_idx;
  wire a_aligned;
  reg [31:0] rd_val;
  reg [3:0] slot;
  reg slot_hit;
  integer i;
  wire wr_fire;
  wire [7:0] wr_byte;
  reg [7:0] rd_byte;
  wire [NDIV-1:0] chan_down;
  wire [NDIV-1:0] dcc_off;

  assign trans_ok = hsel & hready & htrans[1];
  assign a_idx = haddr[11:2];
  assign a_aligned = (haddr[1:0] == 2'b00) & (haddr[31:12] == 20'h00000);

  // ------------------------------------------------------------
  // Sync pin and source edge
  // ------------------------------------------------------------
  // Sync is asynchronous to clk, so it passes two flops first
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_meta_q <= 1'b0;
      sync_q <= 1'b0;
      src_prev_q <= 1'b0;
    end else begin
      sync_meta_q <= sync_req;
      sync_q <= sync_meta_q;
      src_prev_q <= src_clk_level;
    end
  end

  assign src_rise = src_clk_level & ~src_prev_q;

  // ------------------------------------------------------------
  // Address phase capture
  // ------------------------------------------------------------
  // Reads take one wait state so a preceding write is visible
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= 10'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        hreadyout <= 1'b1;
      end else if (trans_ok) begin
        idx_q <= a_aligned ? a_idx : 10'h3ff;
        wr_pend_q <= hwrite;
        rd_pend_q <= ~hwrite;
        hreadyout <= hwrite;
      end else if (hready) begin
        wr_pend_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  // One decoder gives the array slot to both writes and reads
  always @* begin
    slot = 4'h0;
    slot_hit = 1'b1;
    case (idx_q)
      `CCD_IDX_DIV0_COUNTS: begin
        slot = 4'h0;
      end
      `CCD_IDX_DIV0_CONTROL: begin
        slot = 4'h1;
      end
      `CCD_IDX_CH0_POWER: begin
        slot = 4'h2;
      end
      `CCD_IDX_DIV1_COUNTS: begin
        slot = 4'h3;
      end
      `CCD_IDX_DIV1_CONTROL: begin
        slot = 4'h4;
      end
      `CCD_IDX_CH1_POWER: begin
        slot = 4'h5;
      end
      `CCD_IDX_DIV2_COUNTS: begin
        slot = 4'h6;
      end
      `CCD_IDX_DIV2_CONTROL: begin
        slot = 4'h7;
      end
      default: begin
        slot_hit = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // Writes land at the end of the data phase, when hwdata stands
  assign wr_fire = wr_pend_q & hready & slot_hit;
  assign wr_byte = hwdata[7:0];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regs_q[0] <= `CCD_RST_DIV0_COUNTS;
      regs_q[1] <= `CCD_RST_CONTROL;
      regs_q[2] <= `CCD_RST_POWER;
      regs_q[3] <= `CCD_RST_DIV1_COUNTS;
      regs_q[4] <= `CCD_RST_CONTROL;
      regs_q[5] <= `CCD_RST_POWER;
      regs_q[6] <= `CCD_RST_DIV2_COUNTS;
      regs_q[7] <= `CCD_RST_CONTROL;
    end else if (wr_fire) begin
      case (slot)
        4'h0: begin
          regs_q[0] <= wr_byte;
        end
        4'h1: begin
          regs_q[1] <= wr_byte;
        end
        4'h2: begin
          // Power registers keep only the two defined bits
          regs_q[2] <= wr_byte & `CCD_PWR_MASK;
        end
        4'h3: begin
          regs_q[3] <= wr_byte;
        end
        4'h4: begin
          regs_q[4] <= wr_byte;
        end
        4'h5: begin
          regs_q[5] <= wr_byte & `CCD_PWR_MASK;
        end
        4'h6: begin
          regs_q[6] <= wr_byte;
        end
        4'h7: begin
          regs_q[7] <= wr_byte;
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always @* begin
    rd_byte = 8'h00;
    case (slot)
      4'h0: begin
        rd_byte = regs_q[0];
      end
      4'h1: begin
        rd_byte = regs_q[1];
      end
      4'h2: begin
        rd_byte = regs_q[2];
      end
      4'h3: begin
        rd_byte = regs_q[3];
      end
      4'h4: begin
        rd_byte = regs_q[4];
      end
      4'h5: begin
        rd_byte = regs_q[5];
      end
      4'h6: begin
        rd_byte = regs_q[6];
      end
      4'h7: begin
        rd_byte = regs_q[7];
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Status bits are read-only; unmapped indices read zero
  always @* begin
    rd_val = 32'h00000000;
    if (slot_hit) begin
      rd_val = {24'h000000, rd_byte};
    end else if (idx_q == `CCD_IDX_STATUS) begin
      rd_val = {24'h000000, 1'b0, sync_q, running[2:0], div_out[2:0]};
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_q) begin
      hrdata <= rd_val;
    end
  end

  // ------------------------------------------------------------
  // Divider channels
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NDIV; g = g + 1) begin : gen_div
      ccd_divider #(
        .CW(CW)
      ) u_div (
        .clk(clk),
        .reset_n(reset_n),
        .src_level(src_clk_level),
        .src_rise(src_rise),
        .low_cnt(regs_q[3*g][`CCD_CNT_LOW_HI:`CCD_CNT_LOW_LO]),
        .high_cnt(regs_q[3*g][`CCD_CNT_HIGH_HI:`CCD_CNT_HIGH_LO]),
        .bypass(regs_q[3*g+1][`CCD_CTL_BYPASS]),
        .ignore_sync(regs_q[3*g+1][`CCD_CTL_IGNORE_SYNC]),
        .force_high(regs_q[3*g+1][`CCD_CTL_FORCE_HIGH]),
        .start_high(regs_q[3*g+1][`CCD_CTL_START_HIGH]),
        .phase(regs_q[3*g+1][`CCD_CTL_PHASE_HI:`CCD_CTL_PHASE_LO]),
        .sync_act(sync_q),
        .div_out_q(div_out[g]),
        .running_q(running[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Output pairs, power-down and duty-cycle correction
  // ------------------------------------------------------------
  // Channel two has no power register here, so its pairs stay on
  genvar p;
  generate
    for (p = 0; p < NDIV; p = p + 1) begin : gen_pwr
      if (p < 2) begin : gen_reg
        assign chan_down[p] = regs_q[3*p+2][`CCD_PWR_DOWN];
        assign dcc_off[p] = regs_q[3*p+2][`CCD_PWR_DCC_OFF];
      end else begin : gen_fixed
        assign chan_down[p] = 1'b0;
        assign dcc_off[p] = 1'b0;
      end
    end
  endgenerate

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pair_out_q <= {3*NDIV{1'b0}};
      pair_oe_q <= {3*NDIV{1'b0}};
      duty_cycle_correction_q <= {NDIV{1'b0}};
    end else begin
      for (i = 0; i < NDIV; i = i + 1) begin
        pair_out_q[3*i] <= div_out[i];
        pair_out_q[3*i+1] <= div_out[i];
        pair_out_q[3*i+2] <= div_out[i];
        pair_oe_q[3*i] <= ~chan_down[i];
        pair_oe_q[3*i+1] <= ~chan_down[i];
        pair_oe_q[3*i+2] <= ~chan_down[i];
        duty_cycle_correction_q[i] <= ~dcc_off[i];
      end
    end
  end

endmodule

`default_nettype wire

// ### dv/ccd_top_assertions.sv
// Bus and output checks for the channel clock dividers
`default_nettype none

module ccd_checker #(
  parameter NDIV = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [NDIV-1:0] div_out,
  input wire logic [3*NDIV-1:0] pair_out_q,
  input wire logic [3*NDIV-1:0] pair_oe_q,
  input wire logic [NDIV-1:0] duty_cycle_correction_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence rd_taken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence wr_taken;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_resp_okay: assert property (!hresp)
    else $error("error response seen");
  chk_write_no_wait: assert property (wr_taken |=> hreadyout)
    else $error("write data phase stalled");
  chk_read_one_wait: assert property (rd_taken |=> one_wait)
    else $error("read wait state wrong");
  chk_stall_cause: assert property
    ($fell(hreadyout) |-> $past(hsel && htrans[1] && !hwrite))
    else $error("stall without a read");
  chk_rdata_stands: assert property
    ($changed(hrdata) |-> !hreadyout || $past(!hreadyout))
    else $error("read data moved outside a read");
  chk_oe_grouped: assert property
    (pair_oe_q[2:0] == {3{pair_oe_q[0]}} &&
    pair_oe_q[5:3] == {3{pair_oe_q[3]}})
    else $error("pairs of one channel disagree");
  chk_ch2_always_on: assert property
    ($past(reset_n) |-> pair_oe_q[8:6] == 3'b111 &&
    duty_cycle_correction_q[2])
    else $error("channel two disabled");
  chk_ch2_pair_copy: assert property
    (pair_out_q[8:6] == {3{$past(div_out[2])}})
    else $error("channel two pairs do not follow divider");
  chk_pairs_follow: assert property
    (pair_out_q[5:0] ==
    {{3{$past(div_out[1])}}, {3{$past(div_out[0])}}})
    else $error("channel zero or one pairs do not follow divider");
endmodule

bind ccd_top ccd_checker #(.NDIV(NDIV)) u_chk (.clk(clk),
  .reset_n(reset_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .div_out(div_out), .pair_out_q(pair_out_q), .pair_oe_q(pair_oe_q),
  .duty_cycle_correction_q(duty_cycle_correction_q));

`default_nettype wire

// ### dv/ccd_top_tb.sv
// Self-checking bench for the channel clock dividers
`include "ccd_regs.vh"
`default_nettype none

module ccd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic src_clk_level, sync_req, src_run, prev;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, div_out, duty_cycle_correction_q;
  logic [8:0] pair_out_q, pair_oe_q;
  logic [7:0] rst [8] = '{8'h77, 8'h00, 8'h00, 8'h33, 8'h00, 8'h00,
    8'h11, 8'h00};
  int fail_count, checked, cyc, t1, t2;
  assign hready = hreadyout;

  ccd_top dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .src_clk_level(src_clk_level), .sync_req(sync_req),
    .div_out(div_out), .pair_out_q(pair_out_q), .pair_oe_q(pair_oe_q),
    .duty_cycle_correction_q(duty_cycle_correction_q));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Divider input: one rise every two system clocks
  always @(posedge clk) if (src_run) src_clk_level <= ~src_clk_level;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_ready;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [9:0] idx,
    input logic [31:0] d);
    haddr <= {20'h0, idx, 2'b00};
    hsel <= 1'b1;
    htrans <= `CCD_HTRANS_NONSEQ;
    hwrite <= w;
    wait_ready;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready;
    rd = hrdata;
  endtask
  // High and low lengths in system clocks, two per input cycle
  task automatic period(input int k, input int hi, input int lo);
    int n;
    do @(posedge clk); while (div_out[k] !== 1'b0);
    do @(posedge clk); while (div_out[k] !== 1'b1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (div_out[k] === 1'b1);
    check(n, hi);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (div_out[k] === 1'b0);
    check(n, lo);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    {reset_n, hsel, haddr, htrans, hwrite, hwdata} = '0;
    {src_clk_level, src_run, sync_req} = '0;
    hsize = `CCD_HSIZE_WORD;
    tick(4);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, `CCD_IDX_DIV0_COUNTS + 10'(i), 32'h0);
      check(rd, {24'h0, rst[i]});
    end
    $display("reset values done");
    src_run <= 1'b1;
    period(0, 16, 16);
    period(1, 8, 8);
    period(2, 4, 4);
    bus(1'b1, `CCD_IDX_DIV0_COUNTS, 32'h0f);
    period(0, 32, 2);
    $display("divide counts done");
    bus(1'b1, `CCD_IDX_DIV0_CONTROL, 32'h80);
    tick(2);
    for (int i = 0; i < 8; i++) begin
      prev = src_clk_level;
      @(posedge clk);
      check(div_out[0], prev);
    end
    $display("bypass done");
    bus(1'b1, `CCD_IDX_DIV0_CONTROL, 32'h60);
    bus(1'b1, `CCD_IDX_DIV1_CONTROL, 32'h10);
    bus(1'b1, `CCD_IDX_DIV2_COUNTS, 32'h33);
    bus(1'b1, `CCD_IDX_DIV2_CONTROL, 32'h03);
    sync_req <= 1'b1;
    tick(10);
    check(div_out, 3'b011);
    bus(1'b0, `CCD_IDX_STATUS, 32'h0);
    check(rd, 32'h43);
    bus(1'b1, `CCD_IDX_DIV0_CONTROL, 32'h40);
    tick(4);
    check(div_out[0], 1'b0);
    sync_req <= 1'b0;
    {t1, t2} = '0;
    for (int i = 1; i < 200; i++) begin
      @(posedge clk);
      if (t1 == 0 && div_out[1] !== 1'b1) t1 = i;
      if (t2 == 0 && div_out[2] !== 1'b0) t2 = i;
    end
    check(t2 - t1, 6);
    $display("sync and phase done");
    bus(1'b1, `CCD_IDX_CH1_POWER, 32'hff);
    bus(1'b0, `CCD_IDX_CH1_POWER, 32'h0);
    check(rd, 32'h05);
    tick(3);
    check(pair_oe_q, 9'h1c7);
    check(duty_cycle_correction_q, 3'b101);
    bus(1'b1, `CCD_IDX_CH0_POWER, 32'h04);
    bus(1'b1, `CCD_IDX_CH1_POWER, 32'h00);
    tick(3);
    check(pair_oe_q, 9'h1f8);
    check(duty_cycle_correction_q, 3'b111);
    bus(1'b1, 10'h198, 32'hff);
    bus(1'b0, 10'h198, 32'h0);
    check(rd, 32'h0);
    $display("power and map done");
    summarize;
  end
endmodule

`default_nettype wire
